// ==== design/power_save_mode_controller_defines.svh ====
// Offsets, fields, reset values and timing counts of the power-mode block
//
// Contract
// - Only power-save instruction enters low power
// - Sleep stops CPU and peripheral clocks; Idle stops CPU
// - Wake on enabled interrupt, reset, watchdog
// - Sleep turns off system clock source
// - Fail-safe monitor inactive during Sleep
// - Low-power RC runs in Sleep with watchdog
// - Watchdog count cleared entering Sleep or Idle
// - Sleep disables system-clocked peripherals
// - Wake resumes on same clock source
// - Idle keeps system clock and peripherals
// - Idle keeps RC if watchdog or monitor
// - Idle exit restores CPU clock at once
// - Coincident interrupt deferred, then wakes immediately
// - Retention needs fuse zero and enable one
// - Two bits select four Sleep variants
// - Standby clear keeps band gaps on
// - Lockout: only power-on or master clear exits
// - Lockout interrupts discarded, not held pending
// - Lockout one or two RC periods plus start
// - Doze slows only CPU, peripherals full speed
// - Doze enable and three-bit ratio field
// - Restore-on-interrupt clears doze on interrupt
// - Retention exit adds supply recovery delay
`ifndef POWER_SAVE_MODE_CONTROLLER_DEFINES_SVH
`define POWER_SAVE_MODE_CONTROLLER_DEFINES_SVH

// Register byte offsets
`define PSM_RESET_CONTROL_OFS 8'h00
`define PSM_CLOCK_DIVIDER_OFS 8'h04
`define PSM_STATUS_OFS 8'h08
// Reset control register fields
`define PSM_RETENTION_EN_BIT 12
`define PSM_VREG_STANDBY_BIT 8
`define PSM_RESET_CONTROL_RST 32'h0000_0100
// Clock divider register fields
`define PSM_RESTORE_INT_BIT 15
`define PSM_RATIO_LSB 12
`define PSM_CPU_SLOW_BIT 11
`define PSM_CLOCK_DIVIDER_RST 32'h0000_0000
// Timing
`define PSM_CLK_PERIOD_NS 8
`define PSM_RC_STARTUP_PERIODS 1
`define PSM_RECOVERY_US 15
`define PSM_RECOVERY_CYCLES ((`PSM_RECOVERY_US * 1000) / `PSM_CLK_PERIOD_NS)
`define PSM_BANDGAP_SAVE_US 10
`define PSM_BANDGAP_SAVE_CYCLES \
  ((`PSM_BANDGAP_SAVE_US * 1000) / `PSM_CLK_PERIOD_NS)

`endif

// ==== design/power_save_mode_pkg.sv ====
// Types shared by the power-mode block
`default_nettype none
package power_save_mode_pkg;
  // Gray codes along run -> lockout -> asleep -> recover
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_LOCKOUT = 3'h1,
    ST_SLEEP = 3'h3,
    ST_RECOVER = 3'h2,
    ST_IDLE = 3'h4
  } pm_state_t;
  typedef enum logic [1:0] {
    SLEEP_FAST_WAKE = 2'h0,
    SLEEP_NORMAL = 2'h1,
    SLEEP_FAST_RETENTION = 2'h2,
    SLEEP_RETENTION = 2'h3
  } sleep_variant_t;
endpackage
`default_nettype wire

// ==== design/power_save_mode_controller.sv ====
// Sleep, Idle and Doze power-mode controller with AHB-Lite registers
//
// Our own choices: the AHB-Lite slave port and the address map.
`include "power_save_mode_controller_defines.svh"
`default_nettype none
module power_save_mode_controller #(
  parameter int RECOVERY_CYCLES = `PSM_RECOVERY_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic power_save_instruction,
  input wire logic power_save_is_idle,
  input wire logic interrupt_pending,
  input wire logic watchdog_timeout,
  input wire logic watchdog_enabled,
  input wire logic fail_safe_monitor_enabled,
  input wire logic retention_regulator_fuse_n,
  input wire logic master_clear_pin_n,
  input wire logic power_on_reset,
  input wire logic low_power_rc_clock,
  input wire logic low_power_rc_running,
  output logic cpu_clock_enable,
  output logic cpu_halted,
  output logic periph_clock_enable,
  output logic system_clock_source_on,
  output logic fail_safe_clock_monitor_on,
  output logic low_power_rc_clock_on,
  output logic watchdog_timer_clear,
  output logic retention_regulator_on,
  output logic band_gap_on,
  output logic wake_pulse,
  output logic watchdog_wake
);

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Ratio code to divide terminal count
  function automatic logic [7:0] ratio_limit(input logic [2:0] code);
    logic [8:0] div;
    div = (code == 3'h0) ? 9'h001 : 9'h001 << ({1'b0, code} + 4'h1);
    ratio_limit = 8'(div - 9'h001);
  endfunction

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] o);
    addr_hit = (a == o);
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] clear_pin_sync_reg;
  logic [1:0] por_sync_reg;
  logic [2:0] rc_sync_reg;
  logic [1:0] rc_run_sync_reg;
  // Two stages before any logic reads a pin; third rc stage for edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clear_pin_sync_reg <= 2'h3;
      por_sync_reg <= 2'h0;
      rc_sync_reg <= 3'h0;
      rc_run_sync_reg <= 2'h0;
    end
    else
    begin
      clear_pin_sync_reg <= {clear_pin_sync_reg[0], master_clear_pin_n};
      por_sync_reg <= {por_sync_reg[0], power_on_reset};
      rc_sync_reg <= {rc_sync_reg[1:0], low_power_rc_clock};
      rc_run_sync_reg <= {rc_run_sync_reg[0], low_power_rc_running};
    end
  end
  wire hard_reset = !clear_pin_sync_reg[1] || por_sync_reg[1];
  wire rc_rise = rc_sync_reg[1] && !rc_sync_reg[2];
  wire rc_was_running = rc_run_sync_reg[1];

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  logic [31:0] reset_control_reg;
  logic [31:0] clock_divider_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] rd_addr;
  power_save_mode_pkg::pm_state_t state_reg;
  power_save_mode_pkg::pm_state_t state_next;

  // Address phase decode
  wire bus_take = hsel && htrans[1] && hready;
  wire bus_wr = bus_take && hwrite;
  wire [7:0] bus_addr = haddr[7:0];
  assign rd_addr = bus_addr;
  wire [31:0] status_word = {29'h0, state_reg};
  // Unmapped reads return zero, writes dropped
  wire [31:0] rd_data =
    addr_hit(rd_addr, `PSM_RESET_CONTROL_OFS) ? reset_control_reg :
    addr_hit(rd_addr, `PSM_CLOCK_DIVIDER_OFS) ? clock_divider_reg :
    addr_hit(rd_addr, `PSM_STATUS_OFS) ? status_word : 32'h0;

  // Slave always zero wait state, OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= bus_wr;
      wr_addr_reg <= bus_addr;
      hrdata <= (bus_take && !hwrite) ? rd_data : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------
  wire retention_bit = reset_control_reg[`PSM_RETENTION_EN_BIT];
  wire vreg_standby = reset_control_reg[`PSM_VREG_STANDBY_BIT];
  wire restore_bit = clock_divider_reg[`PSM_RESTORE_INT_BIT];
  wire slow_bit = clock_divider_reg[`PSM_CPU_SLOW_BIT];
  wire [2:0] ratio_code = clock_divider_reg[`PSM_RATIO_LSB +: 3];
  wire in_low_power = (state_reg != power_save_mode_pkg::ST_RUN);
  wire doze_clear = restore_bit && interrupt_pending && !in_low_power;
  // retention needs fuse zero and enable
  wire retention_ok = !retention_regulator_fuse_n && retention_bit;
  wire [1:0] variant = {retention_ok, vreg_standby};
  wire retention_sleep = variant[1];

  // Register writes; doze clear wins over software write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reset_control_reg <= `PSM_RESET_CONTROL_RST;
      clock_divider_reg <= `PSM_CLOCK_DIVIDER_RST;
    end
    else
    begin
      if (wr_pend_reg && addr_hit(wr_addr_reg, `PSM_RESET_CONTROL_OFS))
      begin
        reset_control_reg <= hwdata & 32'h0000_1100;
      end
      if (wr_pend_reg && addr_hit(wr_addr_reg, `PSM_CLOCK_DIVIDER_OFS))
      begin
        clock_divider_reg <= hwdata & 32'h0000_f800;
      end
      if (doze_clear)
      begin
        clock_divider_reg[`PSM_CPU_SLOW_BIT] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------
  logic [1:0] lock_cnt_reg;
  logic [1:0] lock_cnt_next;
  logic [15:0] recov_cnt_reg;
  logic [15:0] recov_cnt_next;
  logic clear_pulse;
  logic wake_now;
  logic wd_wake_now;

  // wake sources; deferred interrupt still seen after entry
  wire wake_any = interrupt_pending || watchdog_timeout;

  // source held over from lockout stays masked
  logic lock_mask_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lock_mask_reg <= 1'b0;
    end
    else
    begin
      lock_mask_reg <= wake_any && (lock_mask_reg ||
        (state_reg == power_save_mode_pkg::ST_LOCKOUT));
    end
  end

  always_comb
  begin
    state_next = state_reg;
    lock_cnt_next = lock_cnt_reg;
    recov_cnt_next = recov_cnt_reg;
    clear_pulse = 1'b0;
    wake_now = 1'b0;
    wd_wake_now = 1'b0;
    case (state_reg)
      power_save_mode_pkg::ST_RUN:
      begin
        if (power_save_instruction)
        begin
          clear_pulse = 1'b1;
          if (power_save_is_idle)
          begin
            state_next = power_save_mode_pkg::ST_IDLE;
          end
          else if (retention_sleep)
          begin
            // one period if running, else two plus start-up
            lock_cnt_next = rc_was_running ? 2'h1 :
              2'(2 + `PSM_RC_STARTUP_PERIODS);
            state_next = power_save_mode_pkg::ST_LOCKOUT;
          end
          else
          begin
            state_next = power_save_mode_pkg::ST_SLEEP;
          end
        end
      end
      power_save_mode_pkg::ST_LOCKOUT:
      begin
        // interrupts discarded; lockout counts RC edges
        if (rc_rise)
        begin
          lock_cnt_next = lock_cnt_reg - 2'h1;
          if (lock_cnt_reg == 2'h1)
          begin
            state_next = power_save_mode_pkg::ST_SLEEP;
          end
        end
      end
      power_save_mode_pkg::ST_SLEEP:
      begin
        if (wake_any && !lock_mask_reg)
        begin
          wd_wake_now = watchdog_timeout;
          // retention exit waits for supply recovery
          if (retention_sleep)
          begin
            recov_cnt_next = 16'(RECOVERY_CYCLES);
            state_next = power_save_mode_pkg::ST_RECOVER;
          end
          else if (!variant[0])
          begin
            wake_now = 1'b1;
            state_next = power_save_mode_pkg::ST_RUN;
          end
          else
          begin
            // band gaps off cost extra recovery
            recov_cnt_next = 16'(`PSM_BANDGAP_SAVE_CYCLES);
            state_next = power_save_mode_pkg::ST_RECOVER;
          end
        end
      end
      power_save_mode_pkg::ST_RECOVER:
      begin
        recov_cnt_next = recov_cnt_reg - 16'h1;
        if (recov_cnt_reg <= 16'h1)
        begin
          wake_now = 1'b1;
          state_next = power_save_mode_pkg::ST_RUN;
        end
      end
      power_save_mode_pkg::ST_IDLE:
      begin
        if (wake_any)
        begin
          wake_now = 1'b1;
          wd_wake_now = watchdog_timeout;
          state_next = power_save_mode_pkg::ST_RUN;
        end
      end
      default:
      begin
        state_next = power_save_mode_pkg::ST_RUN;
      end
    endcase
  end

  // State registers; hard reset returns any state to run, Doze kept
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= power_save_mode_pkg::ST_RUN;
      lock_cnt_reg <= 2'h0;
      recov_cnt_reg <= 16'h0;
    end
    else if (hard_reset)
    begin
      state_reg <= power_save_mode_pkg::ST_RUN;
      lock_cnt_reg <= 2'h0;
      recov_cnt_reg <= 16'h0;
    end
    else
    begin
      state_reg <= state_next;
      lock_cnt_reg <= lock_cnt_next;
      recov_cnt_reg <= recov_cnt_next;
    end
  end

  // ------------------------------------------------------------
  // Doze divider
  // ------------------------------------------------------------
  logic [7:0] doze_cnt_reg;
  wire doze_on = slow_bit && !doze_clear;
  wire doze_tick = !doze_on || (doze_cnt_reg >= ratio_limit(ratio_code));
  // CPU enable once per ratio, peripherals untouched
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      doze_cnt_reg <= 8'h00;
    end
    else
    begin
      doze_cnt_reg <= doze_tick ? 8'h00 : doze_cnt_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  wire next_run = (state_next == power_save_mode_pkg::ST_RUN);
  wire next_idle = (state_next == power_save_mode_pkg::ST_IDLE);
  wire next_sleep = !next_run && !next_idle;
  // Outputs from flops so the core sees glitch-free controls
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_clock_enable <= 1'b0;
      cpu_halted <= 1'b0;
      periph_clock_enable <= 1'b1;
      system_clock_source_on <= 1'b1;
      fail_safe_clock_monitor_on <= 1'b0;
      low_power_rc_clock_on <= 1'b0;
      watchdog_timer_clear <= 1'b0;
      retention_regulator_on <= 1'b0;
      band_gap_on <= 1'b1;
      wake_pulse <= 1'b0;
      watchdog_wake <= 1'b0;
    end
    else
    begin
      cpu_clock_enable <= next_run && doze_tick && !hard_reset;
      cpu_halted <= !next_run;
      periph_clock_enable <= !next_sleep;
      // system clock source off in Sleep
      system_clock_source_on <= !next_sleep;
      // monitor idle while source is off
      fail_safe_clock_monitor_on <= fail_safe_monitor_enabled && !next_sleep;
      // keep RC alive for watchdog or monitor
      low_power_rc_clock_on <= watchdog_enabled ||
        (fail_safe_monitor_enabled && !next_sleep) ||
        (state_next == power_save_mode_pkg::ST_LOCKOUT);
      watchdog_timer_clear <= clear_pulse && !hard_reset;
      retention_regulator_on <= next_sleep && retention_sleep;
      band_gap_on <= !next_sleep || !vreg_standby;
      wake_pulse <= wake_now && !hard_reset;
      watchdog_wake <= wd_wake_now && !hard_reset;
    end
  end

endmodule
`default_nettype wire

// ==== tb/power_mode_checker.sv ====
// Port-level assertions for the power-mode controller
`default_nettype none
module power_mode_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic power_save_instruction,
  input wire logic interrupt_pending,
  input wire logic watchdog_timeout,
  input wire logic watchdog_enabled,
  input wire logic retention_regulator_fuse_n,
  input wire logic cpu_clock_enable,
  input wire logic cpu_halted,
  input wire logic periph_clock_enable,
  input wire logic system_clock_source_on,
  input wire logic fail_safe_clock_monitor_on,
  input wire logic low_power_rc_clock_on,
  input wire logic watchdog_timer_clear,
  input wire logic retention_regulator_on,
  input wire logic wake_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------------------
  // Entry, exit and clocks while halted
  // ------------------------------------------------------------
  property p_enter;
    power_save_instruction && !cpu_halted |=> cpu_halted;
  endproperty
  a_enter: assert property (p_enter) else $error("no halt");
  property p_no_stray_halt;
    $rose(cpu_halted) |-> $past(power_save_instruction);
  endproperty
  a_no_stray_halt: assert property (p_no_stray_halt)
    else $error("stray");
  property p_watchdog_clear;
    power_save_instruction && !cpu_halted && watchdog_enabled
      |=> watchdog_timer_clear ##1 !watchdog_timer_clear;
  endproperty
  a_watchdog_clear: assert property (p_watchdog_clear)
    else $error("clear");
  property p_sleep_clocks;
    !system_clock_source_on |-> !fail_safe_clock_monitor_on &&
      !periph_clock_enable && (low_power_rc_clock_on || !watchdog_enabled);
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks)
    else $error("sleep");
  property p_idle_wake;
    cpu_halted && periph_clock_enable &&
      (interrupt_pending || watchdog_timeout) |=> !cpu_halted;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle wake");
  property p_retention;
    retention_regulator_on |-> !retention_regulator_fuse_n &&
      !system_clock_source_on;
  endproperty
  a_retention: assert property (p_retention) else $error("retention");
  property p_wake;
    wake_pulse |-> !cpu_halted && $past(cpu_halted);
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_halt_clk;
    cpu_halted |-> !cpu_clock_enable;
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("cpu clock");
endmodule

bind power_save_mode_controller power_mode_checker checker_i (.*);
`default_nettype wire

// ==== tb/cpu_side_model.sv ====
// Interrupt source and low-power RC oscillator on the CPU side
`default_nettype none
module cpu_side_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic rc_enable,
  input wire logic irq_raise,
  input wire logic irq_drop,
  input wire logic wake_pulse,
  output logic interrupt_pending,
  output logic low_power_rc_clock,
  output logic low_power_rc_running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] rc_div_reg;
  // Pending until dropped or serviced at wake; RC parked low while stopped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      interrupt_pending <= 1'b0;
      rc_div_reg <= 4'h0;
      low_power_rc_clock <= 1'b0;
      low_power_rc_running <= 1'b0;
    end
    else
    begin
      interrupt_pending <= irq_raise | (interrupt_pending & ~irq_drop &
        ~wake_pulse);
      rc_div_reg <= rc_div_reg + 4'h1;
      low_power_rc_clock <= rc_enable & rc_div_reg[3];
      low_power_rc_running <= rc_enable;
    end
  end
endmodule
`default_nettype wire

// ==== tb/power_save_mode_controller_test.sv ====
// Self-checking bench for the power-mode controller
`default_nettype none
module power_save_mode_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, power_save_instruction, power_save_is_idle;
  logic watchdog_timeout, watchdog_enabled, fail_safe_monitor_enabled;
  logic retention_regulator_fuse_n, master_clear_pin_n, power_on_reset;
  logic interrupt_pending, low_power_rc_clock, low_power_rc_running;
  logic [31:0] haddr, hwdata, hrdata, rd, wd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, cpu_clock_enable, cpu_halted, periph_clock_enable;
  logic system_clock_source_on, fail_safe_clock_monitor_on, band_gap_on;
  logic low_power_rc_clock_on, watchdog_timer_clear, retention_regulator_on;
  logic wake_pulse, watchdog_wake, rc_enable, irq_raise, irq_drop;
  wire logic hready;
  int num_errors = 0;
  int check_count = 0;
  int gap;
  // Ratio code, slow enable, expected cycles between cpu clock pulses
  int rows [9][3] = '{'{0, 1, 1}, '{1, 1, 4}, '{2, 1, 8}, '{3, 1, 16},
    '{4, 1, 32}, '{5, 1, 64}, '{6, 1, 128}, '{7, 1, 256}, '{7, 0, 1}};
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  // Short recovery keeps the run brief
  power_save_mode_controller #(.RECOVERY_CYCLES(4)) dut (.*);
  cpu_side_model partner (.hclk(hclk), .hresetn(hresetn),
    .rc_enable(rc_enable), .irq_raise(irq_raise), .irq_drop(irq_drop),
    .wake_pulse(wake_pulse), .interrupt_pending(interrupt_pending),
    .low_power_rc_clock(low_power_rc_clock),
    .low_power_rc_running(low_power_rc_running));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One word transfer; read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic wait_val(ref logic s, input logic v, input int n);
    repeat (n) if (s !== v) @(posedge hclk);
    chk(s, v);
  endtask

  task automatic pulse_irq();
    irq_raise <= 1'b1;
    @(posedge hclk);
    irq_raise <= 1'b0;
  endtask

  // Afterwards the sampled outputs are those of the cycle after entry
  task automatic enter(input logic idle);
    power_save_instruction <= 1'b1;
    power_save_is_idle <= idle;
    @(posedge hclk);
    power_save_instruction <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic gap_of();
    gap = 0;
    do
    begin
      @(posedge hclk);
      gap++;
    end
    while (cpu_clock_enable !== 1'b1 && gap < 600);
  endtask

  task automatic end_of_test();
    $display("%0d errors in %0d checks", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial
  begin
    repeat (40000) @(posedge hclk);
    num_errors++;
    end_of_test();
  end

  initial
  begin
    {hsel, hwrite, power_save_instruction, power_save_is_idle} = 4'h0;
    {watchdog_timeout, power_on_reset, rc_enable, irq_raise} = 4'h0;
    {irq_drop, hresetn, haddr, hwdata, htrans, hsize} = '0;
    {watchdog_enabled, fail_safe_monitor_enabled} = 2'h3;
    {retention_regulator_fuse_n, master_clear_pin_n} = 2'h3;
    tick(5);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h100);
    chk({hreadyout, hresp, cpu_halted, cpu_clock_enable}, 4'h9);
    bus(1'b1, 32'hc, 32'hffff_ffff);
    bus(1'b0, 32'hc, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      wd = (rows[i][0] << 12) | (rows[i][1] << 11);
      bus(1'b1, 32'h4, wd);
      bus(1'b0, 32'h4, 32'h0);
      chk(rd, wd);
      gap_of();
      gap_of();
      chk(gap, rows[i][2]);
    end
    bus(1'b1, 32'h4, 32'h0);
    // Interrupt already pending at the instruction
    pulse_irq();
    enter(1'b1);
    chk({cpu_halted, watchdog_timer_clear, periph_clock_enable}, 3'h7);
    chk({system_clock_source_on, low_power_rc_clock_on}, 2'h3);
    @(posedge hclk);
    chk({cpu_halted, wake_pulse}, 2'h1);
    enter(1'b1);
    watchdog_timeout <= 1'b1;
    wait_val(cpu_halted, 1'b0, 4);
    watchdog_timeout <= 1'b0;
    chk(watchdog_wake, 1'b1);
    // Fuse unprogrammed: retention request falls back to fast wake
    bus(1'b1, 32'h0, 32'h1000);
    enter(1'b0);
    chk({system_clock_source_on, periph_clock_enable}, 2'h0);
    chk({fail_safe_clock_monitor_on, low_power_rc_clock_on}, 2'h1);
    chk({band_gap_on, retention_regulator_on}, 2'h2);
    tick(20);
    pulse_irq();
    wait_val(cpu_halted, 1'b0, 6);
    chk(system_clock_source_on, 1'b1);
    bus(1'b1, 32'h0, 32'h100);
    enter(1'b0);
    chk(band_gap_on, 1'b0);
    watchdog_timeout <= 1'b1;
    @(posedge hclk);
    watchdog_timeout <= 1'b0;
    tick(1200);
    chk(cpu_halted, 1'b1);
    wait_val(cpu_halted, 1'b0, 200);
    // Retention with the RC stopped: lockout holds until RC runs
    retention_regulator_fuse_n <= 1'b0;
    bus(1'b1, 32'h0, 32'h1000);
    enter(1'b0);
    pulse_irq();
    tick(5);
    chk(cpu_halted, 1'b1);
    irq_drop <= 1'b1;
    bus(1'b0, 32'h8, 32'h0);
    irq_drop <= 1'b0;
    chk(rd[2:0], 3'h1);
    rc_enable <= 1'b1;
    tick(100);
    bus(1'b0, 32'h8, 32'h0);
    chk({rd[2:0], cpu_halted, retention_regulator_on}, 5'hf);
    pulse_irq();
    tick(2);
    chk(cpu_halted, 1'b1);
    wait_val(cpu_halted, 1'b0, 12);
    enter(1'b0);
    tick(40);
    bus(1'b0, 32'h8, 32'h0);
    chk(rd[2:0], 3'h3);
    pulse_irq();
    wait_val(cpu_halted, 1'b0, 12);
    rc_enable <= 1'b0;
    tick(3);
    // Lockout stuck with RC stopped: master clear, then power-on
    for (int k = 0; k < 2; k++)
    begin
      enter(1'b0);
      {master_clear_pin_n, power_on_reset} <= k == 0 ? 2'h0 : 2'h3;
      tick(3);
      {master_clear_pin_n, power_on_reset} <= 2'h2;
      wait_val(cpu_halted, 1'b0, 6);
    end
    // Restore-on-interrupt set, then clear
    retention_regulator_fuse_n <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wd = k == 0 ? 32'h9800 : 32'h1800;
      bus(1'b1, 32'h4, wd);
      pulse_irq();
      tick(4);
      irq_drop <= 1'b1;
      bus(1'b0, 32'h4, 32'h0);
      irq_drop <= 1'b0;
      chk(rd, k == 0 ? 32'h9000 : 32'h1800);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
